/* File: design/dramio_regs.svh */
// constants for the direct ram parallel in/out block
`ifndef DRAMIO_REGS_SVH
`define DRAMIO_REGS_SVH

// default transmit source and capture destination addresses
`define DRAMIO_SRC_ADDR      32'h1800_1000
`define DRAMIO_DST_ADDR      32'h1800_0000
// bytes moved per run, both directions
`define DRAMIO_COUNT         9'h100
// setup and hold in peripheral clock cycles
`define DRAMIO_SETUP_PCK     4'h2
`define DRAMIO_HOLD_PCK      4'h2
// strobe active width in peripheral clock cycles
`define DRAMIO_STROBE_PCK    4'h1
// clock periods in ns and the derived mclk cycles per peripheral cycle
`define DRAMIO_MCLK_NS       5
`define DRAMIO_PCK_NS        25
`define DRAMIO_PCK_DIV       ((`DRAMIO_PCK_NS + `DRAMIO_MCLK_NS - 1) / `DRAMIO_MCLK_NS)
// strobe polarity encodings
`define DRAMIO_POL_LOW       1'h0
`define DRAMIO_POL_HIGH      1'h1
// event edge encodings
`define DRAMIO_EDGE_NONE     2'h0
`define DRAMIO_EDGE_RISE     2'h1
`define DRAMIO_EDGE_FALL     2'h2
`define DRAMIO_EDGE_BOTH     2'h3

`endif

/* File: design/dramio_pkg.sv */
// types shared by the direct ram parallel in/out block
`default_nettype none
package dramio_pkg;

	// output port configuration
	typedef struct packed {
		logic        strobePol;   // 1: strobe active high
		logic        strobePinSel; // strobe pin function selected
		logic        irqMask;     // 1: interrupt request masked
		logic [3:0]  setupPck;    // setup in peripheral cycles
		logic [3:0]  holdPck;     // hold in peripheral cycles
		logic [31:0] srcAddr;     // first ram address to send
		logic [8:0]  count;       // bytes per run
	} dramio_outcfg_s;

	// input port configuration
	typedef struct packed {
		logic [1:0]  edgeSel;     // event edge type
		logic        bankSel;     // address counter in use
		logic [31:0] dstAddr;     // first ram address to fill
		logic [8:0]  count;       // bytes per run
	} dramio_incfg_s;

	// output port sequencer states
	typedef enum logic [2:0] {
		DRAMIO_IDLE   = 3'h0,
		DRAMIO_FETCH  = 3'h1,
		DRAMIO_LATCH  = 3'h2,
		DRAMIO_SETUP  = 3'h3,
		DRAMIO_STROBE = 3'h4,
		DRAMIO_HOLD   = 3'h5,
		DRAMIO_DONE   = 3'h6
	} dramio_state_e;

endpackage : dramio_pkg
`default_nettype wire

/* File: design/dramio_capture.sv */
// input port: edge-triggered byte capture into system ram
`default_nettype none
`include "dramio_regs.svh"
module dramio_capture (
	input  wire logic                  mclk,
	input  wire logic                  rst_b,
	input  wire dramio_pkg::dramio_incfg_s cfg,
	input  wire logic                  captureEnable,
	input  wire logic                  inputEventPin,
	input  wire logic [7:0]            inputDataBus,
	output logic                       ramWrEn,
	output logic [31:0]                ramWrAddr,
	output logic [7:0]                 ramWrData,
	output logic                       captureDone
);

	logic       evPrev;          // event level of the previous edge
	logic [8:0] taken;           // bytes captured this run
	logic [8:0] bankOfs [2];     // per-bank address counters
	logic [8:0] next_bankOfs [2];
	logic       next_evPrev;
	logic [8:0] next_taken;
	logic       next_done;
	logic       next_wrEn;
	logic [31:0] next_wrAddr;
	logic [7:0] next_wrData;
	logic       hit;             // a selected edge seen now
	logic       rise;
	logic       fall;

	// edge detect, bank counters and ram write
	always_comb begin
		rise = ~evPrev & inputEventPin;
		fall = evPrev & ~inputEventPin;
		unique case (cfg.edgeSel)
			`DRAMIO_EDGE_RISE: hit = rise;
			`DRAMIO_EDGE_FALL: hit = fall;
			`DRAMIO_EDGE_BOTH: hit = rise | fall;
			`DRAMIO_EDGE_NONE: hit = 1'b0;
		endcase
		next_evPrev = inputEventPin;
		next_taken  = taken;
		next_done   = captureDone;
		next_wrEn   = 1'b0;
		next_wrAddr = ramWrAddr;
		next_wrData = ramWrData;
		next_bankOfs[0] = bankOfs[0];
		next_bankOfs[1] = bankOfs[1];
		if (!captureEnable) begin
			// disabled: ignore events, rearm for a new run
			next_taken = 9'h000;
			next_done  = 1'b0;
			next_bankOfs[0] = 9'h000;
			next_bankOfs[1] = 9'h000;
		end else if (hit && !captureDone) begin
			// latch on the detecting edge, no extra delay
			next_wrEn   = 1'b1;
			next_wrData = inputDataBus;
			next_wrAddr = cfg.dstAddr + {23'h0, bankOfs[cfg.bankSel]};
			next_bankOfs[cfg.bankSel] = bankOfs[cfg.bankSel] + 9'h001;
			next_taken  = taken + 9'h001;
			if (next_taken == cfg.count) begin
				next_done = 1'b1;
			end
		end
	end

	// registers of the capture path
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			evPrev      <= 1'b1;
			taken       <= 9'h000;
			captureDone <= 1'b0;
			ramWrEn     <= 1'b0;
			ramWrAddr   <= 32'h0000_0000;
			ramWrData   <= 8'h00;
			bankOfs[0]  <= 9'h000;
			bankOfs[1]  <= 9'h000;
		end else begin
			evPrev      <= next_evPrev;
			taken       <= next_taken;
			captureDone <= next_done;
			ramWrEn     <= next_wrEn;
			ramWrAddr   <= next_wrAddr;
			ramWrData   <= next_wrData;
			bankOfs[0]  <= next_bankOfs[0];
			bankOfs[1]  <= next_bankOfs[1];
		end
	end

endmodule : dramio_capture
`default_nettype wire

/* File: design/dramio_top.sv */
// direct ram parallel port pair: strobed output and event capture
`default_nettype none
`include "dramio_regs.svh"
module dramio_top (
	input  wire logic                   mclk,
	input  wire logic                   rst_b,
	input  wire dramio_pkg::dramio_outcfg_s outCfg,
	input  wire dramio_pkg::dramio_incfg_s  inCfg,
	input  wire logic                   outputEnable,
	input  wire logic                   captureEnable,
	output logic                        ramRdEn,
	output logic [31:0]                 ramRdAddr,
	input  wire logic [7:0]             ramRdData,
	output logic [7:0]                  outputDataBus,
	output logic                        outputDataOe,
	output logic                        outputStrobe,
	output logic                        outputStrobeOe,
	output logic                        outputIrq,
	output logic                        outputDone,
	input  wire logic                   inputEventPin,
	input  wire logic [7:0]             inputDataBus,
	output logic                        ramWrEn,
	output logic [31:0]                 ramWrAddr,
	output logic [7:0]                  ramWrData,
	output logic                        captureDone
);

	localparam int PCK_DIV = `DRAMIO_PCK_DIV; // mclk cycles per pck
	// the peripheral clock is a fixed division of mclk, so every
	// peripheral-cycle setting below is scaled by this ratio
	// a ratio that does not divide evenly rounds up, so a setup or
	// hold interval is never shorter than asked for
	// the capture side samples on mclk, faster than the event pin moves

	// sequencer state and its phase countdown: loaded on entry to a
	// phase, the phase ends when the countdown reaches one
	dramio_pkg::dramio_state_e state;      // output sequencer state
	dramio_pkg::dramio_state_e next_state;
	logic [7:0] timer;                     // phase countdown, mclk cycles
	logic [7:0] next_timer;
	logic [8:0] sent;                      // bytes sent this run
	logic [8:0] next_sent;
	logic [7:0] next_data;
	logic       strobeOn;                  // strobe asserted, logical
	logic       next_strobeOn;
	logic       irqPend;                   // run finished, not yet rearmed
	logic       next_irqPend;
	// phase lengths in mclk cycles: setup and hold from the configuration, width from the fixed strobe setting
	logic [7:0] setupCycles;
	logic [7:0] holdCycles;
	logic [7:0] widthCycles;

	// peripheral-cycle settings scaled to mclk cycles
	// every four-bit setting times the present ratio stays below 256,
	// so the narrowing to eight bits loses nothing
	// the strobe width is fixed at one peripheral cycle
	always_comb begin
		setupCycles = 8'(32'(outCfg.setupPck) * PCK_DIV);
		holdCycles  = 8'(32'(outCfg.holdPck) * PCK_DIV);
		widthCycles = 8'(32'(`DRAMIO_STROBE_PCK) * PCK_DIV);
	end

	// per byte: FETCH issues the ram read, LATCH puts the answer on
	// the data pins, SETUP waits, STROBE drives the strobe active,
	// HOLD keeps the data after the trailing edge
	// the byte count advances at the end of HOLD, so the next address
	// is ready in time for the next FETCH
	// a finished run waits in DONE; only a dropped enable rearms it
	// output sequencer: fetch, setup, strobe, hold, per byte
	always_comb begin
		// by default hold the state and count the phase timer down
		next_state    = state;
		next_timer    = (timer > 8'h01) ? timer - 8'h01 : 8'h00;
		next_sent     = sent;
		next_data     = outputDataBus;
		// the strobe drops unless a phase below keeps it up
		next_strobeOn = 1'b0;
		next_irqPend  = irqPend;
		ramRdEn       = 1'b0;
		// the read address follows the count of bytes already sent
		ramRdAddr     = outCfg.srcAddr + {23'h0, sent};
		unique case (state)
			dramio_pkg::DRAMIO_IDLE: begin
				// wait for output enable; no ram read, the strobe stays inactive
				next_sent = 9'h000;
				if (outputEnable) begin
					next_state = dramio_pkg::DRAMIO_FETCH;
				end
			end
			dramio_pkg::DRAMIO_FETCH: begin
				// one-cycle ram read of the next byte
				ramRdEn    = 1'b1;
				next_state = dramio_pkg::DRAMIO_LATCH;
			end
			dramio_pkg::DRAMIO_LATCH: begin
				// present data, then wait the setup time
				// ram answers one cycle after the read enable
				next_data  = ramRdData;
				next_timer = setupCycles;
				next_state = dramio_pkg::DRAMIO_SETUP;
			end
			dramio_pkg::DRAMIO_SETUP: begin
				// data already on the pins; count the setup time down
				if (timer <= 8'h01) begin
					// setup done: raise the strobe
					next_strobeOn = 1'b1;
					next_timer    = widthCycles;
					next_state    = dramio_pkg::DRAMIO_STROBE;
				end
			end
			dramio_pkg::DRAMIO_STROBE: begin
				// strobe active; data held through its trailing edge
				if (timer <= 8'h01) begin
					next_timer = holdCycles;
					next_state = dramio_pkg::DRAMIO_HOLD;
				end else begin
					// keep the strobe active until the width runs out
					next_strobeOn = 1'b1;
				end
			end
			dramio_pkg::DRAMIO_HOLD: begin
				// strobe inactive, data still held on the pins
				if (timer <= 8'h01) begin
					next_sent = sent + 9'h001;
					if (next_sent == outCfg.count) begin
						// last byte: stop and flag the end of the run
						next_state   = dramio_pkg::DRAMIO_DONE;
						next_irqPend = 1'b1;
					end else begin
						// more to send: fetch the next byte
						next_state = dramio_pkg::DRAMIO_FETCH;
					end
				end
			end
			dramio_pkg::DRAMIO_DONE: begin
				// stopped; clearing enable rearms for another run
				if (!outputEnable) begin
					next_irqPend = 1'b0;
					next_state   = dramio_pkg::DRAMIO_IDLE;
				end
			end
			default: begin
				// unused code: recover to idle
				next_state = dramio_pkg::DRAMIO_IDLE;
			end
		endcase
	end

	// reset leaves the strobe inactive and the pins at zero, so the
	// far side sees no transfer until an enable has been seen
	// output sequencer registers
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			// asynchronous reset to idle
			state         <= dramio_pkg::DRAMIO_IDLE;
			timer         <= 8'h00;
			sent          <= 9'h000;
			outputDataBus <= 8'h00;
			strobeOn      <= 1'b0;
			irqPend       <= 1'b0;
		end else begin
			// register the next values
			state         <= next_state;
			timer         <= next_timer;
			sent          <= next_sent;
			outputDataBus <= next_data;
			strobeOn      <= next_strobeOn;
			irqPend       <= next_irqPend;
		end
	end

	// polarity only changes how the logical strobe shows on the pin;
	// with the idle logical strobe low, the pin rests at the inactive
	// level for either polarity setting
	// the done flag shows even when the request is masked, so a
	// polling controller still sees the end of a run
	// pin levels: polarity, pin function, masked request
	always_comb begin
		outputStrobe   = (outCfg.strobePol == `DRAMIO_POL_HIGH) ?
			strobeOn : ~strobeOn;
		outputStrobeOe = outCfg.strobePinSel;
		// data pins driven whenever the strobe pin function is on
		outputDataOe   = outCfg.strobePinSel;
		outputDone     = irqPend;
		// the mask gates only the request, never the done flag
		outputIrq      = irqPend & ~outCfg.irqMask;
	end

	// the capture engine shares clock and reset and has no link to the
	// output sequencer; in loop-back the strobe reaches it only
	// through the far-side wiring
	// input port capture engine
	dramio_capture capture (
		.mclk          (mclk),
		.rst_b         (rst_b),
		.cfg           (inCfg),
		.captureEnable (captureEnable),
		.inputEventPin (inputEventPin),
		.inputDataBus  (inputDataBus),
		.ramWrEn       (ramWrEn),
		.ramWrAddr     (ramWrAddr),
		.ramWrData     (ramWrData),
		.captureDone   (captureDone)
	);

endmodule : dramio_top
`default_nettype wire

/* File: verification/dramio_ram_model.sv */
// system ram model answering the output port's reads
`default_nettype none
module dramio_ram_model #(
	parameter logic [7:0] SALT = 8'h5A // fill pattern mixer
) (
	input  wire logic        mclk,
	input  wire logic        rst_b,
	input  wire logic        ramRdEn,
	input  wire logic [31:0] ramRdAddr,
	output logic [7:0]       ramRdData
);
	timeunit 1ns;
	timeprecision 1ps;
	// one cycle read latency; between reads the data wanders
	always @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			ramRdData <= 8'h00;
		end else if (ramRdEn) begin
			ramRdData <= ramRdAddr[7:0] ^ SALT;
		end else begin
			ramRdData <= ~ramRdData;
		end
	end
endmodule : dramio_ram_model
`default_nettype wire

/* File: verification/dramio_chk.sv */
// assertions on the pins of the parallel port pair
`default_nettype none
`include "dramio_regs.svh"
module dramio_chk (
	input wire logic                      mclk,
	input wire logic                      rst_b,
	input wire dramio_pkg::dramio_outcfg_s outCfg,
	input wire dramio_pkg::dramio_incfg_s  inCfg,
	input wire logic                      captureEnable,
	input wire logic                      ramRdEn,
	input wire logic [7:0]                outputDataBus,
	input wire logic                      outputStrobe,
	input wire logic                      outputStrobeOe,
	input wire logic                      outputIrq,
	input wire logic                      outputDone,
	input wire logic                      inputEventPin,
	input wire logic [7:0]                inputDataBus,
	input wire logic                      ramWrEn,
	input wire logic [7:0]                ramWrData,
	input wire logic                      captureDone
);
	timeunit 1ns;
	timeprecision 1ps;
	// strobe at its active level
	logic act;
	assign act = (outputStrobe == outCfg.strobePol);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);
	property p_irq_mask;
		outCfg.irqMask |-> !outputIrq;
	endproperty
	a_irq_mask: assert property (p_irq_mask) else $error("irq masked");
	property p_done_idle;
		outputDone |-> !act && !ramRdEn;
	endproperty
	a_done_idle: assert property (p_done_idle) else $error("done idle");
	property p_pin_sel;
		outputStrobeOe == outCfg.strobePinSel;
	endproperty
	a_pin_sel: assert property (p_pin_sel) else $error("strobe oe");
	property p_width;
		$rose(act) |-> act[*5] ##1 !act;
	endproperty
	a_width: assert property (p_width) else $error("strobe width");
	property p_setup;
		$rose(act) |-> outputDataBus == $past(outputDataBus, 8);
	endproperty
	a_setup: assert property (p_setup) else $error("setup");
	property p_hold;
		$fell(act) |-> (!ramRdEn && $stable(outputDataBus))[*8];
	endproperty
	a_hold: assert property (p_hold) else $error("hold");
	property p_one_read;
		ramRdEn |=> !ramRdEn[*8];
	endproperty
	a_one_read: assert property (p_one_read) else $error("read rate");
	property p_capture;
		captureEnable && !captureDone && $fell(inputEventPin)
		&& inCfg.edgeSel == `DRAMIO_EDGE_FALL
		|=> ramWrEn && ramWrData == $past(inputDataBus);
	endproperty
	a_capture: assert property (p_capture) else $error("capture");
	property p_disarmed;
		!captureEnable |=> !ramWrEn;
	endproperty
	a_disarmed: assert property (p_disarmed) else $error("disarmed");
endmodule : dramio_chk
bind dramio_top dramio_chk chk (.mclk, .rst_b, .outCfg, .inCfg,
	.captureEnable, .ramRdEn, .outputDataBus, .outputStrobe,
	.outputStrobeOe, .outputIrq, .outputDone, .inputEventPin,
	.inputDataBus, .ramWrEn, .ramWrData, .captureDone);
`default_nettype wire

/* File: verification/testbench.sv */
// self-checking bench for the parallel port pair in loop-back
`default_nettype none
`include "dramio_regs.svh"
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] SALT = 8'h5A; // ram fill mixer
	logic mclk = 1'b0, rst_b = 1'b0, outputEnable = 1'b0;
	logic captureEnable = 1'b0, loopBack = 1'b1, evDrv = 1'b1;
	logic prevPin = 1'b1, prevAct = 1'b0;
	logic [7:0] dataDrv = 8'h00, ramRdData, outputDataBus, ramWrData;
	logic [7:0] inputDataBus, expByte;
	logic [31:0] ramRdAddr, ramWrAddr;
	logic ramRdEn, outputDataOe, outputStrobe, outputStrobeOe, outputIrq;
	logic outputDone, ramWrEn, captureDone, inputEventPin, act;
	dramio_pkg::dramio_outcfg_s outCfg = '{1'b1, 1'b1, 1'b1, 4'h2, 4'h2,
		`DRAMIO_SRC_ADDR, `DRAMIO_COUNT};
	dramio_pkg::dramio_incfg_s inCfg = '{`DRAMIO_EDGE_FALL, 1'b0,
		`DRAMIO_DST_ADDR, `DRAMIO_COUNT};
	int num_errors = 0, cmp_count = 0, seed = 32'ha9e6aa26, cycles = 0;
	int nOut = 0, nCap = 0, nWr = 0;
	logic [39:0] expQ [$]; // expected address and byte per capture
	logic [39:0] expWr; // expected address and byte of one write
	// loop-back wiring or bench-driven capture pins
	assign inputEventPin = loopBack ? outputStrobe : evDrv;
	assign inputDataBus = loopBack ? outputDataBus : dataDrv;
	assign act = (outputStrobe === outCfg.strobePol);
	always #2.5 mclk = ~mclk;
	dramio_top uut (.mclk, .rst_b, .outCfg, .inCfg, .outputEnable,
		.captureEnable, .ramRdEn, .ramRdAddr, .ramRdData, .outputDataBus,
		.outputDataOe, .outputStrobe, .outputStrobeOe, .outputIrq,
		.outputDone, .inputEventPin, .inputDataBus, .ramWrEn, .ramWrAddr,
		.ramWrData, .captureDone);
	dramio_ram_model #(.SALT(SALT)) ram (.mclk, .rst_b, .ramRdEn,
		.ramRdAddr, .ramRdData);
	function automatic logic [7:0] memByte(input logic [31:0] a);
		return a[7:0] ^ SALT;
	endfunction : memByte
	// selected edge between last and current pin level
	function automatic logic edgeHit(input logic p, input logic c,
		input logic [1:0] s);
		return (s[1] && p && !c) || (s[0] && !p && c);
	endfunction : edgeHit
	task automatic chk(input logic ok, input string msg);
		cmp_count++;
		if (ok !== 1'b1) begin
			num_errors++;
			$display("mismatch %0t %s", $time, msg);
		end
	endtask : chk
	task automatic test_done();
		if (num_errors == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : test_done
	// hang guard
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			test_done();
		end
	end
	// reference capture model and strobe monitor
	always @(posedge mclk) begin
		if (rst_b && ramWrEn) begin
			nWr++;
			chk(expQ.size() > 0, "extra capture");
			if (expQ.size() > 0) expWr = expQ.pop_front();
			chk({ramWrAddr, ramWrData} === expWr, "capture");
		end
		if (rst_b && captureEnable && nCap < inCfg.count
			&& edgeHit(prevPin, inputEventPin, inCfg.edgeSel)) begin
			expByte = memByte(outCfg.srcAddr + nCap);
			if (loopBack) chk(inputDataBus === expByte, "loop byte");
			expQ.push_back({inCfg.dstAddr + nCap, inputDataBus});
			nCap++;
		end
		if (!captureEnable) nCap = 0;
		if (rst_b && act && !prevAct) begin
			chk(outputDataBus === memByte(outCfg.srcAddr + nOut), "out");
			nOut++;
		end
		prevPin = rst_b ? inputEventPin : 1'b1;
		prevAct = act;
	end
	// one loop-back run; capture armed before output
	task automatic run(input logic pol, input logic msk,
		input logic [8:0] n, input logic [3:0] su, input logic [3:0] ho);
		@(negedge mclk);
		loopBack = 1'b1;
		outCfg = '{pol, 1'b1, msk, su, ho, `DRAMIO_SRC_ADDR, n};
		inCfg = '{pol ? `DRAMIO_EDGE_FALL : `DRAMIO_EDGE_RISE,
			1'($random(seed)), `DRAMIO_DST_ADDR, n};
		nOut = 0;
		nWr = 0;
		@(negedge mclk);
		captureEnable = 1'b1;
		@(negedge mclk);
		outputEnable = 1'b1;
		for (int i = 0; i < 8000 && !outputDone; i++) @(negedge mclk);
		repeat (3) @(negedge mclk);
		chk(nOut == n && nWr == n && captureDone === 1'b1, "count");
		chk(outputIrq === !msk, "irq");
		outputEnable = 1'b0;
		captureEnable = 1'b0;
	endtask : run
	initial begin
		repeat (10) @(negedge mclk);
		rst_b = 1'b1;
		chk(!act && outputDataOe === 1'b1 && outputIrq === 1'b0, "rst");
		loopBack = 1'b0;
		repeat (40) begin
			@(negedge mclk);
			evDrv = 1'($random(seed));
			dataDrv = 8'($random(seed));
		end
		chk(nWr == 0 && nOut == 0, "idle");
		run(1'b1, 1'b1, `DRAMIO_COUNT, 4'h2, 4'h2);
		repeat (6) run(1'($random(seed)), 1'($random(seed)),
			9'(1 + $unsigned($random(seed)) % 4),
			4'(2 + $unsigned($random(seed)) % 3),
			4'(2 + $unsigned($random(seed)) % 3));
		// direct capture under every edge selection
		for (int e = 0; e < 4; e++) begin
			@(negedge mclk);
			loopBack = 1'b0;
			inCfg.edgeSel = 2'(e);
			inCfg.count = 9'h004;
			nWr = 0;
			@(negedge mclk);
			captureEnable = 1'b1;
			repeat (60) begin
				@(negedge mclk);
				evDrv = 1'($random(seed));
				dataDrv = 8'($random(seed));
			end
			// let a capture seen at the last edge reach the write port
			repeat (2) @(negedge mclk);
			chk(nWr == (e ? 4 : 0) && captureDone === (e != 0), "edges");
			captureEnable = 1'b0;
		end
		test_done();
	end
endmodule : testbench
`default_nettype wire
